// file: hdl/pmc_pkg.sv
// Package for the power mode controller: modes, constants and carriers
package pmc_pkg;

  typedef enum logic [2:0]
  {
    PMC_RUN      = 3'b000,
    PMC_WAIT     = 3'b001,
    PMC_AHALT    = 3'b010,
    PMC_HALT     = 3'b011,
    PMC_STARTUP  = 3'b100,
    PMC_WAKE     = 3'b101
  } pmc_state_e;

  localparam logic [7:0]  PMC_OPC_HALT      = 8'h8E;
  localparam logic [1:0]  PMC_IMASK_ENTRY   = 2'h2;
  localparam logic [1:0]  PMC_IMASK_RESET   = 2'h3;
  localparam logic [1:0]  PMC_IMASK_INTWAKE = 2'h3;
  localparam int          PMC_STARTUP_CYC   = 4096;
  localparam logic [12:0] PMC_CNT_RESET     = 13'h0000;
  localparam logic [15:0] PMC_RESET_VECTOR  = 16'hFFFE;
  localparam logic [15:0] PMC_VECTOR_BASE   = 16'hFFFA;

  // Instruction execute strobes from the CPU core
  typedef struct packed
  {
    logic       exec_valid;
    logic [7:0] opcode;
    logic       wait_for_interrupt_instr;
  } pmc_instr_s;

  // Interrupt request summary from the interrupt controller
  typedef struct packed
  {
    logic       irq_pending;
    logic       irq_halt_wake;
    logic       timebase_irq;
    logic [3:0] irq_index;
    logic [1:0] irq_priority;
  } pmc_irq_s;

endpackage

// file: hdl/pmc_ctrl.sv
// Power mode controller: wait, active-halt and halt sequencing
`timescale 1ns/10ps
`default_nettype none

module pmc_ctrl
  import pmc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // CPU core
  input  wire pmc_instr_s  instr,
  input  wire logic        cc_pop,
  input  wire logic [1:0]  cc_pop_mask,
  output logic             cpu_stop,
  output logic [1:0]       cc_imask,
  output logic             cc_imask_load,
  output logic             cc_push,
  output logic             pc_load,
  output logic [15:0]      pc_vector,
  // Interrupt sources and wake reset
  input  wire pmc_irq_s    irq,
  input  wire logic        wake_reset,
  // Clock controller and watchdog
  input  wire logic        timebase_irq_enable,
  input  wire logic        watchdog_active,
  input  wire logic        watchdog_halt_option,
  output logic             osc_enable,
  output logic             periph_clk_enable,
  output logic             timebase_clk_enable,
  output logic             watchdog_reset_req,
  output logic [2:0]       power_mode
);

  pmc_state_e  state;
  pmc_state_e  next_state;
  logic [12:0] cnt;
  logic [12:0] next_cnt;
  logic        from_reset;
  logic        next_from_reset;
  logic        next_cpu_stop;
  logic [1:0]  next_cc_imask;
  logic        next_cc_imask_load;
  logic        next_cc_push;
  logic        next_pc_load;
  logic [15:0] next_pc_vector;
  logic        next_osc_enable;
  logic        next_periph_clk_enable;
  logic        next_timebase_clk_enable;
  logic        next_watchdog_reset_req;
  logic        halt_exec;
  logic        wfi_exec;

  // Vector address of an interrupt slot, two bytes per slot downward
  function automatic logic [15:0] vec_addr(input logic [3:0] idx);
    vec_addr = PMC_VECTOR_BASE - {11'h000, idx, 1'b0};
  endfunction

  assign halt_exec = instr.exec_valid && (instr.opcode == PMC_OPC_HALT);
  assign wfi_exec  = instr.exec_valid && instr.wait_for_interrupt_instr;

  always_comb
  begin
    next_state               = state;
    next_cnt                 = cnt;
    next_from_reset          = from_reset;
    next_cc_imask            = cc_imask;
    next_cc_imask_load       = 1'b0;
    next_cc_push             = 1'b0;
    next_pc_load             = 1'b0;
    next_pc_vector           = pc_vector;
    next_watchdog_reset_req  = 1'b0;
    case (state)
      PMC_RUN:
      begin
        if (wfi_exec)
        begin
          next_state         = PMC_WAIT;
          next_cc_imask      = PMC_IMASK_ENTRY;
          next_cc_imask_load = 1'b1;
        end
        else if (halt_exec)
        begin
          next_cc_imask      = PMC_IMASK_ENTRY;
          next_cc_imask_load = 1'b1;
          if (timebase_irq_enable)
          begin
            next_state = PMC_AHALT;
          end
          else if (watchdog_active && watchdog_halt_option)
          begin
            // Halt refused: the watchdog resets the device instead
            next_watchdog_reset_req = 1'b1;
          end
          else
          begin
            next_state = PMC_HALT;
          end
        end
        else if (irq.irq_pending)
        begin
          // Normal service entry
          next_cc_push       = 1'b1;
          next_cc_imask      = irq.irq_priority;
          next_cc_imask_load = 1'b1;
          next_pc_load       = 1'b1;
          next_pc_vector     = vec_addr(irq.irq_index);
          next_state         = PMC_WAKE;
        end
        else if (cc_pop)
        begin
          next_cc_imask      = cc_pop_mask;
          next_cc_imask_load = 1'b1;
        end
      end
      PMC_WAIT:
      begin
        if (wake_reset)
        begin
          next_state     = PMC_RUN;
          next_pc_load   = 1'b1;
          next_pc_vector = PMC_RESET_VECTOR;
          next_cc_imask  = PMC_IMASK_RESET;
          next_cc_imask_load = 1'b1;
        end
        else if (irq.irq_pending)
        begin
          next_state         = PMC_WAKE;
          next_cc_push       = 1'b1;
          next_cc_imask      = irq.irq_priority;
          next_cc_imask_load = 1'b1;
          next_pc_load       = 1'b1;
          next_pc_vector     = vec_addr(irq.irq_index);
        end
      end
      PMC_AHALT:
      begin
        if (wake_reset)
        begin
          // Reset exit still waits for the oscillator
          next_state      = PMC_STARTUP;
          next_cnt        = PMC_CNT_RESET;
          next_from_reset = 1'b1;
        end
        else if (irq.irq_pending && (irq.timebase_irq || irq.irq_halt_wake))
        begin
          next_state         = PMC_WAKE;
          next_cc_push       = 1'b1;
          next_cc_imask      = irq.irq_priority;
          next_cc_imask_load = 1'b1;
          next_pc_load       = 1'b1;
          next_pc_vector     = vec_addr(irq.irq_index);
        end
      end
      PMC_HALT:
      begin
        if (wake_reset || (irq.irq_pending && irq.irq_halt_wake))
        begin
          next_state      = PMC_STARTUP;
          next_cnt        = PMC_CNT_RESET;
          next_from_reset = wake_reset;
        end
      end
      PMC_STARTUP:
      begin
        if (wake_reset)
        begin
          next_from_reset = 1'b1;
        end
        if (cnt == 13'(PMC_STARTUP_CYC - 1))
        begin
          next_pc_load       = 1'b1;
          next_cc_imask_load = 1'b1;
          if (from_reset || wake_reset)
          begin
            next_state     = PMC_RUN;
            next_pc_vector = PMC_RESET_VECTOR;
            next_cc_imask  = PMC_IMASK_RESET;
          end
          else
          begin
            next_state     = PMC_WAKE;
            next_cc_push   = 1'b1;
            next_cc_imask  = irq.irq_priority;
            next_pc_vector = vec_addr(irq.irq_index);
          end
        end
        else
        begin
          next_cnt = cnt + 13'h0001;
        end
      end
      PMC_WAKE:
      begin
        // One cycle for the CPU to take the vector
        next_state = PMC_RUN;
      end
      default:
      begin
        next_state = PMC_RUN;
      end
    endcase
    next_cpu_stop            = (next_state != PMC_RUN) && (next_state != PMC_WAKE);
    next_osc_enable          = (next_state != PMC_HALT);
    next_timebase_clk_enable = (next_state != PMC_HALT);
    next_periph_clk_enable   = (next_state == PMC_RUN) || (next_state == PMC_WAIT)
                             || (next_state == PMC_WAKE);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state               <= PMC_RUN;
      cnt                 <= PMC_CNT_RESET;
      from_reset          <= 1'b0;
      cpu_stop            <= 1'b0;
      cc_imask            <= PMC_IMASK_RESET;
      cc_imask_load       <= 1'b0;
      cc_push             <= 1'b0;
      pc_load             <= 1'b0;
      pc_vector           <= PMC_RESET_VECTOR;
      osc_enable          <= 1'b1;
      periph_clk_enable   <= 1'b1;
      timebase_clk_enable <= 1'b1;
      watchdog_reset_req  <= 1'b0;
      power_mode          <= PMC_RUN;
    end
    else
    begin
      state               <= next_state;
      cnt                 <= next_cnt;
      from_reset          <= next_from_reset;
      cpu_stop            <= next_cpu_stop;
      cc_imask            <= next_cc_imask;
      cc_imask_load       <= next_cc_imask_load;
      cc_push             <= next_cc_push;
      pc_load             <= next_pc_load;
      pc_vector           <= next_pc_vector;
      osc_enable          <= next_osc_enable;
      periph_clk_enable   <= next_periph_clk_enable;
      timebase_clk_enable <= next_timebase_clk_enable;
      watchdog_reset_req  <= next_watchdog_reset_req;
      power_mode          <= next_state;
    end
  end

  wait_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_RUN && wfi_exec) |=> (state == PMC_WAIT && cc_imask == 2'h2 && cpu_stop))
    else $error("wait entry wrong");
  mask_force_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_RUN && halt_exec && !(watchdog_active && watchdog_halt_option
     && !timebase_irq_enable)) |=> (cc_imask == 2'h2 && cc_imask_load))
    else $error("mask not forced on halt entry");
  halt_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_RUN && halt_exec && timebase_irq_enable) |=> state == PMC_AHALT)
    else $error("active-halt not selected");
  ahalt_fast_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_AHALT && !wake_reset && irq.irq_pending && irq.timebase_irq)
    |=> (state == PMC_WAKE && pc_load))
    else $error("active-halt interrupt exit delayed");
  ahalt_clk_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_AHALT) |-> (!periph_clk_enable && osc_enable && timebase_clk_enable))
    else $error("active-halt clocks wrong");
  halt_osc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_HALT) |-> (!osc_enable && !periph_clk_enable))
    else $error("oscillator running in halt");
  startup_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(state == PMC_STARTUP) |-> !pc_load [*8])
    else $error("start-up delay cut short");
  startup_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_STARTUP && cnt == 13'h0FFF) |=> (pc_load && state != PMC_STARTUP))
    else $error("start-up delay end wrong");
  wait_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_WAIT && wake_reset) |=> (pc_vector == 16'hFFFE && state == PMC_RUN))
    else $error("reset did not win in wait");
  wdg_halt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_RUN && halt_exec && timebase_irq_enable) |=> !watchdog_reset_req)
    else $error("watchdog reset in active-halt");
  wait_clk_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_WAIT) |-> (cpu_stop && periph_clk_enable && osc_enable))
    else $error("wait mode clocks wrong");
  wait_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_WAIT && !wake_reset && irq.irq_pending)
    |=> (state == PMC_WAKE && pc_load))
    else $error("wait mode did not wake on interrupt");
  svc_push_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_WAIT && !wake_reset && irq.irq_pending)
    |=> (cc_push && cc_imask_load && cc_imask == $past(irq.irq_priority)))
    else $error("service entry did not push or set priority");
  pop_restore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_RUN && cc_pop && !wfi_exec && !halt_exec && !irq.irq_pending)
    |=> (cc_imask_load && cc_imask == $past(cc_pop_mask)))
    else $error("pop did not restore mask");
  ahalt_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_AHALT && wake_reset) |=> (state == PMC_STARTUP && cnt == 13'h0000))
    else $error("reset exit from active-halt skipped start-up");
  pending_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_AHALT && !wake_reset && irq.irq_pending && irq.irq_halt_wake)
    |=> (state == PMC_WAKE && pc_load))
    else $error("pending interrupt did not wake active-halt");
  halt_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_HALT && irq.irq_pending && irq.irq_halt_wake)
    |=> (state == PMC_STARTUP && osc_enable && !pc_load))
    else $error("halt wake did not restart oscillator");
  halt_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_HALT && !wake_reset && !(irq.irq_pending && irq.irq_halt_wake))
    |=> (state == PMC_HALT && !osc_enable))
    else $error("halt left without a wake source");
  wdg_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_RUN && halt_exec && !timebase_irq_enable && watchdog_active
     && watchdog_halt_option) |=> (watchdog_reset_req && state == PMC_RUN))
    else $error("watchdog halt option ignored");
  other_opcode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_RUN && instr.exec_valid && !instr.wait_for_interrupt_instr
     && instr.opcode != PMC_OPC_HALT) |=> (!cpu_stop && !watchdog_reset_req))
    else $error("non-halt opcode stopped the core");
  startup_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_STARTUP && cnt != 13'h0FFF) |=> (state == PMC_STARTUP && !pc_load))
    else $error("start-up left early");
  reset_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == PMC_STARTUP && cnt == 13'h0FFF && from_reset)
    |=> (state == PMC_RUN && pc_vector == 16'hFFFE && cc_imask == 2'h3))
    else $error("reset exit did not take the reset vector");

endmodule

`default_nettype wire

// file: tb/pmc_irq_model.sv
// Interrupt source model: latched request, cleared by vector fetch
`timescale 1ns/10ps
`default_nettype none
module pmc_irq_model
  import pmc_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rst_n,
  // Requests from the bench
  input  wire pmc_irq_s req,
  input  wire logic     req_set,
  input  wire logic     req_clr,
  // Vector fetch from the controller
  input  wire logic     pc_load,
  output var pmc_irq_s  irq
);
  // Fetching the vector drops the request, as a real latch would
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || req_clr)
      irq <= '0;
    else if (req_set)
      irq <= req;
    else if (pc_load)
      irq <= '0;
  end
endmodule
`default_nettype wire

// file: tb/power_mode_controller_tb.sv
// Self-checking bench for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module power_mode_controller_tb
  import pmc_pkg::*;
;
  logic clk_sys, rst_n, cc_pop, wake_reset, tb_en, wd_act, wd_opt, set, clr;
  logic cpu_stop, cc_imask_load, cc_push, pc_load, osc, per, tbc, wdr;
  logic [1:0] cc_imask, pop_mask;
  logic [15:0] pc_vector;
  logic [2:0] power_mode;
  pmc_instr_s instr;
  pmc_irq_s req, irq;
  int miscompares, comparisons, n;

  pmc_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr(instr), .cc_pop(cc_pop),
    .cc_pop_mask(pop_mask), .cpu_stop(cpu_stop), .cc_imask(cc_imask),
    .cc_imask_load(cc_imask_load), .cc_push(cc_push), .pc_load(pc_load),
    .pc_vector(pc_vector), .irq(irq), .wake_reset(wake_reset),
    .timebase_irq_enable(tb_en), .watchdog_active(wd_act),
    .watchdog_halt_option(wd_opt), .osc_enable(osc), .periph_clk_enable(per),
    .timebase_clk_enable(tbc), .watchdog_reset_req(wdr), .power_mode(power_mode));

  pmc_irq_model partner (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .req_set(set),
    .req_clr(clr), .pc_load(pc_load), .irq(irq));

  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic mode(input logic [2:0] e);
    chk(16'(power_mode), 16'(e), "power mode");
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic exec(input logic [7:0] op, input logic w);
    instr = '{1'b1, op, w};
    step(1);
    instr = '0;
  endtask

  task automatic raise(input logic w, input logic t, input logic [3:0] s,
                       input logic [1:0] p);
    req = '{1'b1, w, t, s, p};
    set = 1'b1;
    step(1);
    set = 1'b0;
  endtask

  // Bounded wait: a lost wake-up must not hang the run
  task automatic wait_pc;
    n = 1;
    while (pc_load !== 1'b1 && n < 5000)
    begin
      step(1);
      n++;
    end
    chk(16'(pc_load), 16'h1, "vector load");
  endtask

  task automatic t_reset;
    mode(PMC_RUN);
    chk({12'h0, cpu_stop, osc, per, tbc}, 16'h7, "reset levels");
    chk({14'h0, cc_imask}, 16'h3, "reset mask");
    chk(pc_vector, PMC_RESET_VECTOR, "reset vector");
  endtask

  task automatic t_wait;
    exec(8'h00, 1'b1);
    mode(PMC_WAIT);
    chk({14'h0, cpu_stop, per}, 16'h3, "wait clocks");
    chk({13'h0, cc_imask_load, cc_imask}, 16'h6, "wait mask");
    step(1);
    exec(PMC_OPC_HALT, 1'b0);
    mode(PMC_WAIT);
    raise(1'b0, 1'b0, 4'h3, 2'h1);
    wait_pc();
    chk(16'(n <= 2), 16'h1, "wait wake time");
    chk(pc_vector, PMC_VECTOR_BASE - 16'h6, "wait vector");
    chk({13'h0, cc_push, cc_imask}, 16'h5, "push and priority");
    step(2);
    mode(PMC_RUN);
    pop_mask = 2'h0;
    cc_pop = 1'b1;
    step(1);
    cc_pop = 1'b0;
    chk({13'h0, cc_imask_load, cc_imask}, 16'h4, "pop restore");
  endtask

  task automatic t_halt;
    tb_en = 1'b0;
    exec(PMC_OPC_HALT, 1'b0);
    mode(PMC_HALT);
    chk({12'h0, osc, per, tbc, cpu_stop}, 16'h1, "halt clocks");
    chk({13'h0, cc_imask_load, cc_imask}, 16'h6, "halt mask");
    raise(1'b0, 1'b0, 4'h4, 2'h1);
    step(2);
    mode(PMC_HALT);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    raise(1'b1, 1'b0, 4'h1, 2'h2);
    step(1);
    mode(PMC_STARTUP);
    chk(16'(osc), 16'h1, "oscillator restart");
    wait_pc();
    chk(16'(n >= 4095 && n <= 4097), 16'h1, "startup length");
    chk(pc_vector, PMC_VECTOR_BASE - 16'h2, "halt vector");
    step(2);
  endtask

  task automatic t_active;
    wd_act = 1'b1;
    wd_opt = 1'b1;
    exec(8'h8F, 1'b0);
    chk({12'h0, wdr, power_mode}, 16'h0, "other opcode");
    step(1);
    exec(PMC_OPC_HALT, 1'b0);
    chk({12'h0, wdr, power_mode}, 16'h8, "watchdog refusal");
    step(1);
    tb_en = 1'b1;
    exec(PMC_OPC_HALT, 1'b0);
    chk({12'h0, wdr, power_mode}, 16'h2, "active halt, no reset");
    chk({13'h0, osc, per, tbc}, 16'h5, "active halt clocks");
    chk({13'h0, cc_imask_load, cc_imask}, 16'h6, "active mask");
    raise(1'b0, 1'b0, 4'h7, 2'h1);
    step(2);
    mode(PMC_AHALT);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    raise(1'b0, 1'b1, 4'h5, 2'h3);
    wait_pc();
    chk(16'(n <= 2), 16'h1, "no startup delay");
    chk(pc_vector, PMC_VECTOR_BASE - 16'hA, "time base vector");
    wd_act = 1'b0;
    step(2);
  endtask

  task automatic t_pending;
    req = '{1'b1, 1'b1, 1'b0, 4'h0, 2'h1};
    set = 1'b1;
    exec(PMC_OPC_HALT, 1'b0);
    set = 1'b0;
    mode(PMC_AHALT);
    wait_pc();
    chk(16'(n <= 2), 16'h1, "pending wake");
    chk(pc_vector, PMC_VECTOR_BASE, "pending vector");
    step(2);
  endtask

  task automatic t_reset_exit;
    exec(PMC_OPC_HALT, 1'b0);
    raise(1'b1, 1'b1, 4'h5, 2'h1);
    wake_reset = 1'b1;
    step(1);
    wake_reset = 1'b0;
    mode(PMC_STARTUP);
    wait_pc();
    chk(pc_vector, PMC_RESET_VECTOR, "reset wins");
    chk({14'h0, cc_imask}, 16'h3, "reset mask");
    step(2);
    mode(PMC_RUN);
    exec(8'h00, 1'b1);
    wake_reset = 1'b1;
    step(1);
    wake_reset = 1'b0;
    chk({10'h0, pc_load, cc_imask, power_mode}, 16'h38, "wait reset exit");
    chk(pc_vector, PMC_RESET_VECTOR, "wait reset vector");
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Longest path is two start-up delays, well under this span
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    {rst_n, cc_pop, wake_reset, tb_en, wd_act, wd_opt, set, clr} = '0;
    pop_mask = 2'h0;
    instr = '0;
    req = '0;
    miscompares = 0;
    comparisons = 0;
    step(6);
    rst_n = 1'b1;
    step(1);
    t_reset();
    t_wait();
    t_halt();
    t_active();
    t_pending();
    t_reset_exit();
    finish_test();
  end
endmodule
`default_nettype wire
